// >>> logic/sync_serial_pkg.sv
// constants shared by the synchronous serial port files
// assumes an 8-bit register port with small word indices
package sync_serial_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CTRL_ONE = 3'h1;
  localparam logic [2:0] ADDR_CTRL_THREE = 3'h2;
  localparam logic [2:0] ADDR_BUFFER = 3'h3;
  localparam logic [2:0] ADDR_RELOAD = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;
  // status register fields
  localparam int STAT_SAMPLE_POS = 7;
  localparam int STAT_EDGE_POS = 6;
  localparam int STAT_FULL_POS = 0;
  localparam logic [7:0] STAT_WR_MASK = 8'hC0;
  // control one fields and the flags register done bit
  localparam int CTRL_COLL_POS = 7;
  localparam int CTRL_EN_POS = 5;
  localparam int CTRL_IDLE_POS = 4;
  localparam int FLAG_DONE_POS = 0;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_THREE_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] BUFFER_RST = 8'h00;
  // mode field encodings
  localparam logic [3:0] MODE_HOST_DIV4 = 4'h0;
  localparam logic [3:0] MODE_HOST_DIV16 = 4'h1;
  localparam logic [3:0] MODE_HOST_DIV64 = 4'h2;
  localparam logic [3:0] MODE_HOST_TIMER = 4'h3;
  localparam logic [3:0] MODE_CLIENT_SEL = 4'h4;
  localparam logic [3:0] MODE_CLIENT_FREE = 4'h5;
  localparam logic [3:0] MODE_HOST_RELOAD = 4'hA;
  // half periods of the host clock in system clocks
  localparam logic [9:0] HALF_DIV4 = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;
  // byte framing
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  // host exchange state
  typedef enum logic {XFER_IDLE, XFER_SHIFT} xfer_state_type;
endpackage

// >>> logic/reset_release.sv
// two-stage release of the asynchronous reset
// assumes arst_n_i may drop at any time and rise at any time
`timescale 1ns/1ps
module reset_release (
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // raw reset, active low
  output logic rst_n_o // released reset, active low
);
  logic stage_ff;
  logic sync_ff;

  // shift ones in after release
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      stage_ff <= 1'b1;
      sync_ff <= stage_ff;
    end
  end

  assign rst_n_o = sync_ff;
endmodule

// >>> logic/serial_rate_divider.sv
// host serial clock half-period tick generator
// assumes timer_i is a one-cycle pulse from an external timer
`timescale 1ns/1ps
module serial_rate_divider (
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // released reset, active low
  input wire logic ce_i, // clock enable
  input wire logic run_i, // host exchange running
  input wire logic [3:0] mode_i, // rate selection
  input wire logic [7:0] reload_i, // rate reload value
  input wire logic timer_i, // timer output pulse
  output logic tick_o // one half period elapsed
);
  logic [9:0] cnt_ff;
  logic [9:0] nxt_cnt;
  logic [9:0] half;

  // half period from the rate selection
  always_comb
  begin
    unique case (mode_i)
      sync_serial_pkg::MODE_HOST_DIV16: half = sync_serial_pkg::HALF_DIV16;
      sync_serial_pkg::MODE_HOST_DIV64: half = sync_serial_pkg::HALF_DIV64;
      sync_serial_pkg::MODE_HOST_RELOAD: half = 10'({2'h0, reload_i} + 10'h001) << 1;
      default: half = sync_serial_pkg::HALF_DIV4;
    endcase
    if (mode_i == sync_serial_pkg::MODE_HOST_TIMER)
      tick_o = run_i & timer_i;
    else
      tick_o = run_i & (cnt_ff == 10'(half - 10'h001));
    if (!run_i || tick_o)
      nxt_cnt = 10'h000;
    else
      nxt_cnt = 10'(cnt_ff + 10'h001);
  end

  // counter register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_ff <= 10'h000;
    else if (ce_i)
      cnt_ff <= nxt_cnt;
  end
endmodule

// >>> logic/sync_serial_port.sv
// synchronous serial port, host or client, with its register file
// assumes all pin inputs are synchronous to clock_i
// Operation
// - eight-bit shift register, MSb out first, LSb in from data line
// - drive on the configured clock edge, sample on the other
// - byte ends after eight serial clock cycles, contents swapped
// - full received byte goes to the buffer, done flag set
// - buffer write loads buffer and shift register together
// - host drives serial clock; client takes it as input
// - config selects role, idle level, sample point, edge, rate, select
// - runs only while enabled; disabling allows reconfiguration
// - buffer-full bit set with the done flag on each byte
// - next byte may arrive before the last one is read
// - buffer write during a transfer is dropped, collision flag set
// - reading the buffer clears buffer-full
// - shift register has no software path except via the buffer
// - status low six bits read-only, top two and control one writable
// - reload register sets the host clock in the reload rate mode
// - an unselected client ignores the bus and drives nothing
// - both ends share clock polarity; host starts the clock
// - host starts an exchange as soon as the buffer is written
// - host rate is clock/4, /16, /64, timer/2 or reload based
// - client select high floats data out and clears the bit count
// - client sets done flag once the last bit is latched
`timescale 1ns/1ps
module sync_serial_port (
  input wire logic clock_i, // system clock, 20 MHz
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic [2:0] addr_i, // register index
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after the strobe
  input wire logic sck_i, // serial clock pin level
  output logic sck_o, // serial clock drive
  output logic sck_oe_o, // serial clock drive enable
  input wire logic sdi_i, // serial data in
  output logic sdo_o, // serial data out
  output logic sdo_oe_o, // serial data out enable
  input wire logic ss_n_i, // client select, active low
  input wire logic timer_i, // timer output pulse for host rate
  output logic transfer_done_o, // transfer-done flag
  output logic buffer_full_o // buffer-full flag
);
  logic rst_n;
  logic tick;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] ctrl_one_ff, nxt_ctrl_one;
  logic [7:0] ctrl_three_ff, nxt_ctrl_three;
  logic [7:0] reload_ff, nxt_reload;
  logic [7:0] buffer_ff, nxt_buffer;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [3:0] count_ff, nxt_count;
  logic [4:0] ticks_ff, nxt_ticks;
  sync_serial_pkg::xfer_state_type state_ff, nxt_state;
  logic done_ff, nxt_done;
  logic sck_ff, nxt_sck;
  logic sck_prev_ff;
  logic sck_oe_ff, nxt_sck_oe;
  logic sdo_ff, nxt_sdo;
  logic sdo_oe_ff, nxt_sdo_oe;
  logic enabled, host, client, sel_used, selected, idle_lvl, out_edge, late;
  logic busy, buf_wr, buf_rd, sample, drive, clear_count;
  logic [4:0] tick_num, last_tick;

  // host role for the rate modes only; client modes and unused encodings are not host
  function automatic logic is_host(input logic [3:0] mode);
    is_host = (mode == sync_serial_pkg::MODE_HOST_DIV4)
      || (mode == sync_serial_pkg::MODE_HOST_DIV16)
      || (mode == sync_serial_pkg::MODE_HOST_DIV64)
      || (mode == sync_serial_pkg::MODE_HOST_TIMER)
      || (mode == sync_serial_pkg::MODE_HOST_RELOAD);
  endfunction

  // host edge number that captures data for the chosen edge
  function automatic logic is_capture(input logic [4:0] num, input logic edge_sel);
    is_capture = (num != 5'h00) && (num <= sync_serial_pkg::EDGES_PER_BYTE)
      && (num[0] == edge_sel);
  endfunction

  reset_release u_reset (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .rst_n_o(rst_n)
  );

  serial_rate_divider u_rate (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .run_i(state_ff == sync_serial_pkg::XFER_SHIFT),
    .mode_i(ctrl_one_ff[3:0]),
    .reload_i(reload_ff),
    .timer_i(timer_i),
    .tick_o(tick)
  );

  // configuration decode
  always_comb
  begin
    enabled = ctrl_one_ff[sync_serial_pkg::CTRL_EN_POS];
    host = is_host(ctrl_one_ff[3:0]);
    client = (ctrl_one_ff[3:0] == sync_serial_pkg::MODE_CLIENT_SEL)
      || (ctrl_one_ff[3:0] == sync_serial_pkg::MODE_CLIENT_FREE);
    sel_used = ctrl_one_ff[3:0] == sync_serial_pkg::MODE_CLIENT_SEL;
    selected = !sel_used || !ss_n_i;
    idle_lvl = ctrl_one_ff[sync_serial_pkg::CTRL_IDLE_POS];
    out_edge = status_ff[sync_serial_pkg::STAT_EDGE_POS];
    late = host && status_ff[sync_serial_pkg::STAT_SAMPLE_POS];
    busy = enabled && ((state_ff == sync_serial_pkg::XFER_SHIFT) || (count_ff != 4'h0));
    buf_wr = wr_i && (addr_i == sync_serial_pkg::ADDR_BUFFER);
    buf_rd = rd_i && (addr_i == sync_serial_pkg::ADDR_BUFFER);
  end

  // serial edge events for either role
  always_comb
  begin
    tick_num = 5'(ticks_ff + 5'h01);
    last_tick = 5'(sync_serial_pkg::EDGES_PER_BYTE + 5'(late && !out_edge));
    sample = 1'b0;
    drive = 1'b0;
    if (enabled && host && tick)
    begin
      // late sampling moves capture to the end of the bit time
      if (late)
        sample = is_capture(5'(tick_num - 5'h01), out_edge);
      else
        sample = is_capture(tick_num, out_edge);
      drive = (tick_num <= sync_serial_pkg::EDGES_PER_BYTE)
        && (tick_num[0] != out_edge);
    end
    else if (enabled && client && selected && !buf_wr && (sck_i != sck_prev_ff))
    begin
      sample = (sck_i != idle_lvl) == out_edge;
      drive = (sck_i != idle_lvl) != out_edge;
    end
    clear_count = !enabled || (client && sel_used && ss_n_i);
  end

  // shift engine, buffer and flags
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ticks = ticks_ff;
    nxt_count = count_ff;
    nxt_shift = shift_ff;
    nxt_buffer = buffer_ff;
    nxt_sdo = sdo_ff;
    nxt_sck = sck_ff;
    nxt_done = done_ff;
    nxt_status = status_ff;
    nxt_ctrl_one = ctrl_one_ff;
    nxt_ctrl_three = ctrl_three_ff;
    nxt_reload = reload_ff;
    // software side effects first, hardware sets override
    if (buf_rd)
      nxt_status[sync_serial_pkg::STAT_FULL_POS] = 1'b0;
    if (wr_i)
    begin
      unique case (addr_i)
        sync_serial_pkg::ADDR_STATUS:
          nxt_status = (wdata_i & sync_serial_pkg::STAT_WR_MASK)
            | (status_ff & ~sync_serial_pkg::STAT_WR_MASK);
        sync_serial_pkg::ADDR_CTRL_ONE:
        begin
          nxt_ctrl_one = wdata_i;
          nxt_ctrl_one[sync_serial_pkg::CTRL_COLL_POS] =
            wdata_i[sync_serial_pkg::CTRL_COLL_POS]
            && ctrl_one_ff[sync_serial_pkg::CTRL_COLL_POS];
        end
        sync_serial_pkg::ADDR_CTRL_THREE: nxt_ctrl_three = wdata_i;
        sync_serial_pkg::ADDR_RELOAD: nxt_reload = wdata_i;
        sync_serial_pkg::ADDR_FLAGS:
          nxt_done = done_ff && wdata_i[sync_serial_pkg::FLAG_DONE_POS];
        default: nxt_done = nxt_done;
      endcase
    end
    // buffer write: collision, held off, or load both registers
    if (buf_wr && busy)
      nxt_ctrl_one[sync_serial_pkg::CTRL_COLL_POS] = 1'b1;
    else if (buf_wr && !ctrl_one_ff[sync_serial_pkg::CTRL_COLL_POS])
    begin
      nxt_buffer = wdata_i;
      nxt_shift = wdata_i;
      nxt_sdo = wdata_i[7];
      if (enabled && host)
      begin
        nxt_state = sync_serial_pkg::XFER_SHIFT;
        nxt_ticks = 5'h00;
      end
    end
    // host clock toggles on each edge tick
    if (!enabled || !host)
      nxt_sck = idle_lvl;
    else if (tick && (tick_num <= sync_serial_pkg::EDGES_PER_BYTE))
      nxt_sck = !sck_ff;
    if (enabled && host && tick)
    begin
      nxt_ticks = tick_num;
      if (tick_num == last_tick)
        nxt_state = sync_serial_pkg::XFER_IDLE;
    end
    // output next bit, taking a same-edge capture into account
    if (drive)
      nxt_sdo = sample ? shift_ff[6] : shift_ff[7];
    if (sample)
    begin
      nxt_shift = {shift_ff[6:0], sdi_i};
      nxt_count = 4'(count_ff + 4'h1);
      if (count_ff == sync_serial_pkg::BITS_LAST)
      begin
        nxt_count = 4'h0;
        nxt_buffer = {shift_ff[6:0], sdi_i};
        nxt_done = 1'b1;
        nxt_status[sync_serial_pkg::STAT_FULL_POS] = 1'b1;
      end
    end
    if (clear_count)
    begin
      nxt_count = 4'h0;
      nxt_state = sync_serial_pkg::XFER_IDLE;
      nxt_ticks = 5'h00;
    end
  end

  // pin enables and read data
  always_comb
  begin
    nxt_sck_oe = enabled && host;
    nxt_sdo_oe = enabled && (host || (client && selected));
    nxt_rdata = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        sync_serial_pkg::ADDR_STATUS: nxt_rdata = status_ff;
        sync_serial_pkg::ADDR_CTRL_ONE: nxt_rdata = ctrl_one_ff;
        sync_serial_pkg::ADDR_CTRL_THREE: nxt_rdata = ctrl_three_ff;
        sync_serial_pkg::ADDR_BUFFER: nxt_rdata = buffer_ff;
        sync_serial_pkg::ADDR_RELOAD: nxt_rdata = reload_ff;
        sync_serial_pkg::ADDR_FLAGS: nxt_rdata = {7'h00, done_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_ff <= sync_serial_pkg::STATUS_RST;
      ctrl_one_ff <= sync_serial_pkg::CTRL_ONE_RST;
      ctrl_three_ff <= sync_serial_pkg::CTRL_THREE_RST;
      reload_ff <= sync_serial_pkg::RELOAD_RST;
      buffer_ff <= sync_serial_pkg::BUFFER_RST;
      shift_ff <= 8'h00;
      rdata_ff <= 8'h00;
      count_ff <= 4'h0;
      ticks_ff <= 5'h00;
      state_ff <= sync_serial_pkg::XFER_IDLE;
      done_ff <= 1'b0;
      sck_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
      sck_oe_ff <= 1'b0;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      status_ff <= nxt_status;
      ctrl_one_ff <= nxt_ctrl_one;
      ctrl_three_ff <= nxt_ctrl_three;
      reload_ff <= nxt_reload;
      buffer_ff <= nxt_buffer;
      shift_ff <= nxt_shift;
      rdata_ff <= nxt_rdata;
      count_ff <= nxt_count;
      ticks_ff <= nxt_ticks;
      state_ff <= nxt_state;
      done_ff <= nxt_done;
      sck_ff <= nxt_sck;
      sck_prev_ff <= sck_i;
      sck_oe_ff <= nxt_sck_oe;
      sdo_ff <= nxt_sdo;
      sdo_oe_ff <= nxt_sdo_oe;
    end
  end

  // outputs straight from flops
  assign rdata_o = rdata_ff;
  assign sck_o = sck_ff;
  assign sck_oe_o = sck_oe_ff;
  assign sdo_o = sdo_ff;
  assign sdo_oe_o = sdo_oe_ff;
  assign transfer_done_o = done_ff;
  assign buffer_full_o = status_ff[sync_serial_pkg::STAT_FULL_POS];
endmodule

// >>> tb/sync_serial_port_sva.sv
// concurrent checks on the serial port pins and register port
// assumes ce_i is held high and control one is written only through the port
`timescale 1ns/1ps
module sync_serial_port_sva (
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // reset, active low
  input wire logic ce_i, // clock enable
  input wire logic [2:0] addr_i, // register index
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] rdata_o, // read data
  input wire logic sck_o, // serial clock drive
  input wire logic sck_oe_o, // serial clock enable
  input wire logic sdo_oe_o, // data out enable
  input wire logic ss_n_i, // client select
  input wire logic transfer_done_o, // done flag
  input wire logic buffer_full_o // full flag
);
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [1:0] quiet_ff;
  logic [1:0] nxt_quiet;
  logic steady;
  logic en;
  logic host;
  default clocking chk_cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // shadow of control one and cycles since its last write
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_quiet = (quiet_ff == 2'h3) ? quiet_ff : quiet_ff + 2'h1;
    if (wr_i && ce_i && addr_i == sync_serial_pkg::ADDR_CTRL_ONE)
    begin
      nxt_ctrl = wdata_i;
      nxt_quiet = 2'h0;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_ff <= 8'h00;
      quiet_ff <= 2'h0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      quiet_ff <= nxt_quiet;
    end
  end
  // settled configuration decode
  assign steady = quiet_ff == 2'h3;
  assign en = ctrl_ff[sync_serial_pkg::CTRL_EN_POS];
  assign host = ctrl_ff[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
  sequence buf_read_s;
    rd_i && addr_i == sync_serial_pkg::ADDR_BUFFER;
  endsequence
  rd_stand_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  unmapped_rd_a: assert property (rd_i && addr_i > 3'h5 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  host_clk_a: assert property (steady && en && host |-> sck_oe_o)
    else $error("host does not drive clock");
  client_clk_a: assert property (steady && !(en && host) |-> !sck_oe_o)
    else $error("clock driven outside host role");
  deselect_a: assert property (
    steady && en && ctrl_ff[3:0] == 4'h4 && ss_n_i && !wr_i |=> !sdo_oe_o)
    else $error("deselected client drives data");
  idle_lvl_a: assert property (
    steady && en && !host |-> sck_o == ctrl_ff[sync_serial_pkg::CTRL_IDLE_POS])
    else $error("clock not at idle level");
  full_done_a: assert property ($rose(buffer_full_o) |-> transfer_done_o)
    else $error("full without done flag");
  full_clr_a: assert property (buf_read_s |=> !buffer_full_o)
    else $error("buffer read left full flag");
  done_hold_a: assert property (
    transfer_done_o && !(wr_i && addr_i == sync_serial_pkg::ADDR_FLAGS) |=> transfer_done_o)
    else $error("done flag dropped by itself");
endmodule

bind sync_serial_port sync_serial_port_sva chk (.clock_i, .arst_n_i, .ce_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .sck_o, .sck_oe_o, .sdo_oe_o, .ss_n_i, .transfer_done_o, .buffer_full_o);

// >>> tb/spi_client_model.sv
// behavioural client on the far side of the serial link
// assumes clock idle low, data changed on leading edges, taken on trailing
`timescale 1ns/1ps
module spi_client_model (
  input wire logic clock_i, // system clock, samples the link
  input wire logic sel_n_i, // select, active low
  input wire logic sck_i, // serial clock from the host
  input wire logic mosi_i, // data from the host
  input wire logic load_i, // load pulse while deselected
  input wire logic [7:0] byte_i, // byte for the next exchange
  output logic miso_o, // data to the host
  output logic [7:0] shift_o // shift register contents
);
  logic sck_q = 1'b0;
  initial miso_o = 1'b0;
  initial shift_o = 8'h00;
  // msb out on leading edges, lsb in on trailing edges
  always @(posedge clock_i)
  begin
    sck_q <= sck_i;
    if (load_i)
      shift_o <= byte_i;
    else if (sel_n_i)
      miso_o <= ~miso_o; // released line shows no stale bit
    else if (sck_i && !sck_q)
      miso_o <= shift_o[7];
    else if (!sck_i && sck_q)
      shift_o <= {shift_o[6:0], mosi_i};
  end
endmodule

// >>> tb/sync_serial_port_tb.sv
// self-checking bench for the serial port: registers, host and client roles
// assumes the client model above and a 20 MHz system clock
`timescale 1ns/1ps
module sync_serial_port_tb;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic host_sck = 1'b0;
  logic host_sdo = 1'b0;
  logic ss_n_i = 1'b1;
  logic timer_i = 1'b0;
  logic sel_n = 1'b1;
  logic load_en = 1'b0;
  logic [7:0] load_b = 8'h00;
  logic [7:0] lfsr = 8'h15;
  logic [7:0] rdata_o;
  logic [7:0] client_rx;
  logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, transfer_done_o, buffer_full_o, client_miso;
  logic sck_pin;
  logic sdi_pin;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // pin levels seen by every party
  assign sck_pin = sck_oe_o ? sck_o : host_sck;
  assign sdi_pin = sel_n ? host_sdo : client_miso;
  always #25 clock_i = ~clock_i;
  // timer pulse every fourth clock
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    timer_i <= (cyc % 4 == 3);
  end
  sync_serial_port dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck_pin),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(sdi_pin), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .ss_n_i(ss_n_i), .timer_i(timer_i), .transfer_done_o(transfer_done_o),
    .buffer_full_o(buffer_full_o));
  spi_client_model peer (.clock_i(clock_i), .sel_n_i(sel_n), .sck_i(sck_pin), .mosi_i(sdo_o),
    .load_i(load_en), .byte_i(load_b), .miso_o(client_miso), .shift_o(client_rx));
  function automatic logic [7:0] nxt_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("Error %s expected %0h seen %0h", what, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string what);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    check(what, 16'(e), 16'(rdata_o));
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (transfer_done_o !== 1'b1 && n < 2000)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n >= 2000)
    begin
      $display("Error done flag expected 1 seen timeout");
      fail_count++;
      conclude();
    end
  endtask
  // one host exchange against the client model
  task automatic host_xfer(input logic [3:0] mode, input int half, input bit coll);
    logic [7:0] tx;
    int n;
    tx = lfsr;
    lfsr = nxt_rand(lfsr);
    exp_q.push_back(lfsr);
    @(posedge clock_i);
    load_b <= lfsr;
    load_en <= 1'b1;
    lfsr = nxt_rand(lfsr);
    @(posedge clock_i);
    load_en <= 1'b0;
    sel_n <= 1'b0;
    wr(sync_serial_pkg::ADDR_CTRL_ONE, {4'h2, mode});
    wr(sync_serial_pkg::ADDR_BUFFER, tx);
    if (coll)
    begin
      wr(sync_serial_pkg::ADDR_BUFFER, ~tx);
      rd(sync_serial_pkg::ADDR_CTRL_ONE, {4'hA, mode}, "collision");
    end
    wait_done(n);
    if (half != 0)
      check("exchange cycles", 16'(16 * half), 16'(n));
    check("full flag", 16'h0001, 16'(buffer_full_o));
    rd(sync_serial_pkg::ADDR_BUFFER, exp_q.pop_front(), "rx byte");
    check("client got", 16'(tx), 16'(client_rx));
    check("full clear", 16'h0000, 16'(buffer_full_o));
    wr(sync_serial_pkg::ADDR_FLAGS, 8'h00);
    sel_n <= 1'b1;
  endtask
  // bench acting as host towards the client role
  task automatic client_bits(input logic [7:0] tx, input int nbits, output logic [7:0] got);
    got = 8'h00;
    ss_n_i <= 1'b0;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      repeat (4) @(posedge clock_i);
      host_sck <= 1'b1;
      host_sdo <= tx[i];
      repeat (4) @(posedge clock_i);
      host_sck <= 1'b0;
      got = {got[6:0], sdo_o};
    end
  endtask
  // main sequence
  initial
  begin
    logic [7:0] got;
    logic [7:0] ctx;
    int n;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00, "reset value");
    wr(sync_serial_pkg::ADDR_STATUS, 8'hFF);
    rd(sync_serial_pkg::ADDR_STATUS, sync_serial_pkg::STAT_WR_MASK, "status");
    wr(sync_serial_pkg::ADDR_STATUS, 8'h00);
    wr(sync_serial_pkg::ADDR_CTRL_THREE, 8'h5A);
    rd(sync_serial_pkg::ADDR_CTRL_THREE, 8'h5A, "control three");
    wr(sync_serial_pkg::ADDR_RELOAD, 8'h03);
    rd(sync_serial_pkg::ADDR_RELOAD, 8'h03, "reload");
    host_xfer(4'h0, 0, 1'b1);
    wr(sync_serial_pkg::ADDR_BUFFER, 8'h3C);
    repeat (40) @(posedge clock_i);
    check("blocked write", 16'h0000, 16'(transfer_done_o));
    host_xfer(4'h0, 2, 1'b0);
    host_xfer(4'h1, 8, 1'b0);
    host_xfer(4'h2, 32, 1'b0);
    host_xfer(4'hA, 8, 1'b0);
    host_xfer(4'h3, 0, 1'b0);
    // late input sample point in host role
    wr(sync_serial_pkg::ADDR_STATUS, 8'h80);
    host_xfer(4'h1, 0, 1'b0);
    wr(sync_serial_pkg::ADDR_STATUS, 8'h00);
    wr(sync_serial_pkg::ADDR_CTRL_ONE, 8'h34);
    repeat (4) @(posedge clock_i);
    wr(sync_serial_pkg::ADDR_CTRL_ONE, 8'h24);
    ctx = lfsr;
    lfsr = nxt_rand(lfsr);
    wr(sync_serial_pkg::ADDR_BUFFER, ctx);
    client_bits(lfsr, 3, got);
    ss_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    check("data out float", 16'h0000, 16'(sdo_oe_o));
    wr(sync_serial_pkg::ADDR_BUFFER, ctx);
    client_bits(lfsr, 8, got);
    wait_done(n);
    check("client tx", 16'(ctx), 16'(got));
    rd(sync_serial_pkg::ADDR_BUFFER, lfsr, "client rx");
    ss_n_i <= 1'b1;
    conclude();
  end
endmodule
